/* io_read_accumulator_alu.sv */
// Purpose: executes port read, accumulator calculate and compare commands
// Assumes: one command per i_cmd_valid pulse, all command fields same clock
// Notes: reply one cycle after the command; acc and flags feed the sequencer
`timescale 1ns/1ps
`default_nettype none
`include "io_alu_consts.svh"

module io_read_accumulator_alu
    import io_alu_pkg::*;
#(
    parameter int ADC_BITS = 12
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    // command
    input wire logic i_cmd_valid,
    input wire logic i_standalone,
    input wire logic [7:0] i_cmd_instr,
    input wire logic [7:0] i_cmd_type,
    input wire logic [7:0] i_cmd_bank,
    input wire logic [7:0] i_cmd_val_b3,
    input wire logic [7:0] i_cmd_val_b2,
    input wire logic [7:0] i_cmd_val_b1,
    input wire logic [7:0] i_cmd_val_b0,
    // reply
    output logic o_rsp_valid,
    output logic [7:0] o_rsp_status,
    output logic [31:0] o_rsp_value,
    // pins, asynchronous
    input wire logic [`GEN_IN_COUNT-1:0] i_general_input,
    input wire logic i_enc_near_zero,
    // analog values and output states, same clock
    input wire logic [ADC_BITS-1:0] i_adc_in0,
    input wire logic [15:0] i_supply_tenths_v,
    input wire logic [15:0] i_temp_celsius,
    input wire logic [`GEN_OUT_COUNT-1:0] i_general_output,
    // accumulator, flags and branch test
    output logic [31:0] o_acc,
    output logic o_flag_eq,
    output logic o_flag_gt,
    output logic o_flag_lt,
    input wire logic [3:0] i_cond_code,
    output logic o_cond_met
);

    localparam int NIN = `GEN_IN_COUNT;

    acc_word_t acc_ff;
    acc_word_t nxt_acc;
    acc_word_t operand;
    logic flag_eq_ff;
    logic flag_gt_ff;
    logic flag_lt_ff;
    logic [NIN-1:0] in_s1_ff;
    logic [NIN-1:0] in_s2_ff;
    logic [NIN-1:0] in_s3_ff;
    logic [NIN-1:0] in_filt_ff;
    logic enc_s1_ff;
    logic enc_s2_ff;
    logic enc_s3_ff;
    logic enc_filt_ff;
    logic rsp_valid_ff;
    logic [7:0] rsp_status_ff;
    acc_word_t rsp_value_ff;
    acc_word_t port_value;
    logic port_ok;
    logic is_read;
    logic is_accumulator_calculate;
    logic is_comp;
    logic accumulator_calculate_ok;

    // operand assembled most significant byte first
    assign operand = {i_cmd_val_b3, i_cmd_val_b2, i_cmd_val_b1,
                      i_cmd_val_b0};

    assign is_read = i_cmd_valid && (i_cmd_instr == `INSTR_READ_IO_PORT);
    assign is_accumulator_calculate = i_cmd_valid && (i_cmd_instr == `INSTR_ACC_CALCULATE);
    assign is_comp = i_cmd_valid &&
        (i_cmd_instr == `INSTR_COMPARE);
    assign accumulator_calculate_ok = (i_cmd_type <= OP_LOAD);

    // three-stage synchronisers for the pins
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            in_s1_ff <= '0;
            in_s2_ff <= '0;
            in_s3_ff <= '0;
            enc_s1_ff <= 1'b0;
            enc_s2_ff <= 1'b0;
            enc_s3_ff <= 1'b0;
        end else begin
            in_s1_ff <= i_general_input;
            in_s2_ff <= in_s1_ff;
            in_s3_ff <= in_s2_ff;
            enc_s1_ff <= i_enc_near_zero;
            enc_s2_ff <= enc_s1_ff;
            enc_s3_ff <= enc_s2_ff;
        end
    end

    // accept a change once stages two and three agree, per line
    genvar gi;
    generate
        for (gi = 0; gi < NIN; gi++) begin : g_in_filt
            always_ff @(posedge i_clk_sys or negedge i_nrst) begin
                if (!i_nrst) begin
                    in_filt_ff[gi] <= 1'b0;
                end else if (in_s2_ff[gi] == in_s3_ff[gi]) begin
                    in_filt_ff[gi] <= in_s3_ff[gi];
                end
            end
        end
    endgenerate

    // encoder flag filter
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            enc_filt_ff <= 1'b0;
        end else if (enc_s2_ff == enc_s3_ff) begin
            enc_filt_ff <= enc_s3_ff;
        end
    end

    // port selection by bank and port number
    always_comb begin
        port_value = '0;
        port_ok = 1'b1;
        unique case (i_cmd_bank)
            `BANK_DIGITAL_IN: begin
                if (i_cmd_type < 8'(NIN)) begin
                    port_value = {31'h0,
                        in_filt_ff[i_cmd_type[1:0]]};
                end else if (i_cmd_type == `PORT_ALL_INPUTS) begin
                    port_value = 32'(in_filt_ff);
                end else if (i_cmd_type == `PORT_ENC_NEAR_ZERO) begin
                    port_value = {31'h0, enc_filt_ff};
                end else begin
                    port_ok = 1'b0;
                end
            end
            `BANK_ANALOG_IN: begin
                // analog path is separate from the digital filter
                if (i_cmd_type == `PORT_ANALOG_IN0) begin
                    port_value = 32'(i_adc_in0);
                end else if (i_cmd_type == `PORT_SUPPLY_VOLT) begin
                    port_value = 32'(i_supply_tenths_v);
                end else if (i_cmd_type == `PORT_TEMPERATURE) begin
                    port_value = 32'(signed'(i_temp_celsius));
                end else begin
                    port_ok = 1'b0;
                end
            end
            `BANK_DIGITAL_OUT: begin
                if (i_cmd_type < 8'(`GEN_OUT_COUNT)) begin
                    port_value = {31'h0,
                        i_general_output[i_cmd_type[0]]};
                end else begin
                    port_ok = 1'b0;
                end
            end
            default: begin
                port_ok = 1'b0;
            end
        endcase
    end

    // next accumulator value
    always_comb begin
        nxt_acc = acc_ff;
        if (is_read && i_standalone && port_ok) begin
            nxt_acc = port_value;
        end else if (is_accumulator_calculate) begin
            unique case (i_cmd_type)
                OP_ADD: nxt_acc = acc_ff + operand;
                OP_SUB: nxt_acc = acc_ff - operand;
                OP_MUL: nxt_acc = 32'($signed(acc_ff) * $signed(operand));
                OP_DIV: begin
                    if (operand != '0) begin
                        nxt_acc = 32'($signed(acc_ff) / $signed(operand));
                    end
                end
                OP_REMAINDER: begin
                    if (operand != '0) begin
                        nxt_acc = 32'($signed(acc_ff) % $signed(operand));
                    end
                end
                OP_AND: nxt_acc = acc_ff & operand;
                OP_OR: nxt_acc = acc_ff | operand;
                OP_XOR: nxt_acc = acc_ff ^ operand;
                OP_NOT: nxt_acc = ~acc_ff;
                OP_LOAD: nxt_acc = operand;
                default: nxt_acc = acc_ff;
            endcase
        end
    end

    // accumulator register
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            acc_ff <= '0;
        end else begin
            acc_ff <= nxt_acc;
        end
    end

    // compare flags, signed
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            flag_eq_ff <= 1'b0;
            flag_gt_ff <= 1'b0;
            flag_lt_ff <= 1'b0;
        end else if (is_comp) begin
            flag_eq_ff <= (acc_ff == operand);
            flag_gt_ff <= ($signed(acc_ff) > $signed(operand));
            flag_lt_ff <= ($signed(acc_ff) < $signed(operand));
        end
    end

    // reply registers
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            rsp_valid_ff <= 1'b0;
            rsp_status_ff <= 8'h00;
            rsp_value_ff <= '0;
        end else begin
            rsp_valid_ff <= i_cmd_valid;
            if (is_read) begin
                rsp_status_ff <= port_ok ? `STATUS_OK : `STATUS_BAD_TYPE;
                rsp_value_ff <= port_value;
            end else if (is_accumulator_calculate) begin
                rsp_status_ff <= accumulator_calculate_ok ? `STATUS_OK
                                         : `STATUS_BAD_TYPE;
                rsp_value_ff <= operand;
            end else if (is_comp) begin
                rsp_status_ff <= `STATUS_OK;
                rsp_value_ff <= operand;
            end else if (i_cmd_valid) begin
                rsp_status_ff <= `STATUS_BAD_INSTR;
                rsp_value_ff <= '0;
            end
        end
    end

    // branch condition from the stored flags
    always_comb begin
        unique case (i_cond_code)
            CC_ZERO, CC_EQUAL: o_cond_met = flag_eq_ff;
            CC_NOT_ZERO, CC_NOT_EQUAL: o_cond_met = !flag_eq_ff;
            CC_GREATER: o_cond_met = flag_gt_ff;
            CC_GREATER_EQ: o_cond_met = flag_gt_ff || flag_eq_ff;
            CC_LOWER: o_cond_met = flag_lt_ff;
            CC_LOWER_EQ: o_cond_met = flag_lt_ff || flag_eq_ff;
            default: o_cond_met = 1'b0;
        endcase
    end

    // outputs
    assign o_acc = acc_ff;
    assign o_flag_eq = flag_eq_ff;
    assign o_flag_gt = flag_gt_ff;
    assign o_flag_lt = flag_lt_ff;
    assign o_rsp_valid = rsp_valid_ff;
    assign o_rsp_status = rsp_status_ff;
    assign o_rsp_value = rsp_value_ff;

    // assertions, all on the system clock
    default clocking cb_sys @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_nrst);

    sequence seq_read_standalone;
        is_read && i_standalone && port_ok;
    endsequence

    sequence seq_read_direct;
        is_read && !i_standalone;
    endsequence

    sequence seq_accumulator_calculate(logic [7:0] code);
        is_accumulator_calculate && (i_cmd_type == code);
    endsequence

    AST_DIGITAL_BIT: assert property (
        is_read && (i_cmd_bank == `BANK_DIGITAL_IN) && (i_cmd_type < 8'(NIN))
        |=> (o_rsp_value[31:1] == 31'h0))
        else $error("digital read not a single bit");

    AST_ADC_RANGE: assert property (
        is_read && (i_cmd_bank == `BANK_ANALOG_IN) &&
        (i_cmd_type == `PORT_ANALOG_IN0)
        |=> (o_rsp_value <= 32'(`ADC_MAX)) &&
        (o_rsp_value == 32'($past(i_adc_in0))))
        else $error("analog read out of range or wrong");

    AST_READ_LOADS_ACC: assert property (
        seq_read_standalone |=> o_rsp_valid && (o_acc == o_rsp_value))
        else $error("standalone read did not load accumulator");

    AST_DIRECT_KEEPS_ACC: assert property (
        seq_read_direct |=> (o_acc == $past(acc_ff)) && o_rsp_valid)
        else $error("direct read changed accumulator");

    AST_ALL_INPUTS: assert property (
        is_read && (i_cmd_bank == `BANK_DIGITAL_IN) &&
        (i_cmd_type == `PORT_ALL_INPUTS)
        |=> (o_rsp_value == 32'($past(in_filt_ff))))
        else $error("input vector read wrong");

    AST_ACCUMULATOR_CALCULATE_ADD: assert property (
        seq_accumulator_calculate(OP_ADD) |=> (o_acc == $past(acc_ff) + $past(operand)))
        else $error("add result wrong");

    AST_ACCUMULATOR_CALCULATE_LOAD: assert property (
        seq_accumulator_calculate(OP_LOAD) |=> (o_acc == $past(operand)))
        else $error("load result wrong");

    AST_ACCUMULATOR_CALCULATE_NOT: assert property (
        seq_accumulator_calculate(OP_NOT) |=> (o_acc == ~$past(acc_ff)))
        else $error("invert result wrong");

    AST_DIV_ZERO: assert property (
        is_accumulator_calculate && (operand == '0) &&
        ((i_cmd_type == OP_DIV) || (i_cmd_type == OP_REMAINDER))
        |=> $stable(acc_ff))
        else $error("divide by zero changed accumulator");

    AST_ACCUMULATOR_CALCULATE_STATUS: assert property (
        is_accumulator_calculate && accumulator_calculate_ok |=> o_rsp_valid && (o_rsp_status == `STATUS_OK))
        else $error("calculate reply status not 100");

    AST_COMP_FLAGS: assert property (
        is_comp |=> (o_flag_eq == ($past(acc_ff) == $past(operand))) &&
        !(o_flag_gt && o_flag_lt))
        else $error("compare flags wrong");

    AST_COND_GE: assert property (
        (i_cond_code == CC_GREATER_EQ) &&
        (flag_eq_ff || flag_gt_ff || flag_lt_ff)
        |-> (o_cond_met == !flag_lt_ff))
        else $error("greater-or-equal condition wrong");

endmodule : io_read_accumulator_alu

`default_nettype wire

/* io_alu_consts.svh */
// Purpose: named constants of the port-read / accumulator / compare slice
// Assumes: included by its bare name
// Notes: definitions only
`ifndef IO_ALU_CONSTS_SVH
`define IO_ALU_CONSTS_SVH

// instruction numbers
`define INSTR_SET_OUTPUT_PORT 8'h0e
`define INSTR_READ_IO_PORT 8'h0f
`define INSTR_ACC_CALCULATE 8'h13
`define INSTR_COMPARE 8'h14

// reply status codes
`define STATUS_OK 8'h64
`define STATUS_BAD_INSTR 8'h02
`define STATUS_BAD_TYPE 8'h03

// banks
`define BANK_DIGITAL_IN 8'h00
`define BANK_ANALOG_IN 8'h01
`define BANK_DIGITAL_OUT 8'h02

// port numbers
`define PORT_ALL_INPUTS 8'hff
`define PORT_ENC_NEAR_ZERO 8'h0b
`define PORT_SUPPLY_VOLT 8'h08
`define PORT_TEMPERATURE 8'h09
`define PORT_ANALOG_IN0 8'h00

// widths and limits
`define ADC_MAX 12'hfff
`define GEN_IN_COUNT 4
`define GEN_OUT_COUNT 2

`endif

/* io_alu_pkg.sv */
// Purpose: types of the port-read / accumulator / compare slice
// Assumes: nothing
// Notes: constants live in io_alu_consts.svh
package io_alu_pkg;

    typedef logic [31:0] acc_word_t;

    // operation codes carried in the type field of the calculate instruction
    typedef enum logic [7:0] {
        OP_ADD = 8'h00,
        OP_SUB = 8'h01,
        OP_MUL = 8'h02,
        OP_DIV = 8'h03,
        OP_REMAINDER = 8'h04,
        OP_AND = 8'h05,
        OP_OR = 8'h06,
        OP_XOR = 8'h07,
        OP_NOT = 8'h08,
        OP_LOAD = 8'h09
    } accumulator_calculate_op_t;

    // condition codes of the conditional branch
    typedef enum logic [3:0] {
        CC_ZERO = 4'h0,
        CC_NOT_ZERO = 4'h1,
        CC_EQUAL = 4'h2,
        CC_NOT_EQUAL = 4'h3,
        CC_GREATER = 4'h4,
        CC_GREATER_EQ = 4'h5,
        CC_LOWER = 4'h6,
        CC_LOWER_EQ = 4'h7
    } cond_code_t;

endpackage : io_alu_pkg

/* host_model.sv */
// Purpose: host-side model that issues commands and collects replies
// Assumes: fields change 1 ns after a rising edge, one command per call
// Notes: idle fields are scrambled so stale values never pass for valid
`timescale 1ns/1ps
`default_nettype none

module host_model (
    // clock
    input wire logic i_clk_sys,
    // command to the block
    output logic o_cmd_valid,
    output logic o_standalone,
    output logic [7:0] o_cmd_instr,
    output logic [7:0] o_cmd_type,
    output logic [7:0] o_cmd_bank,
    output logic [31:0] o_cmd_val,
    // reply from the block
    input wire logic i_rsp_valid,
    input wire logic [7:0] i_rsp_status,
    input wire logic [31:0] i_rsp_value
);
    // idle values at time zero
    initial begin
        o_cmd_valid = 1'b0;
        o_standalone = 1'b0;
        o_cmd_instr = 8'h5a;
        o_cmd_type = 8'ha5;
        o_cmd_bank = 8'h5a;
        o_cmd_val = 32'ha5a5a5a5;
    end

    // one command strobe, reply taken 1 ns after the taking edge
    task automatic send(input logic sa, input logic [7:0] ins,
        input logic [7:0] typ, input logic [7:0] bnk,
        input logic [31:0] val, output logic rv, output logic [7:0] st,
        output logic [31:0] v);
        // compare goes out as part of a stored program only
        if (ins == 8'h14) begin
            sa = 1'b1;
        end
        // calculate may go out direct; allowed, not preferred
        @(posedge i_clk_sys);
        #1;
        o_cmd_valid = 1'b1;
        o_standalone = sa;
        o_cmd_instr = ins;
        o_cmd_type = typ;
        o_cmd_bank = bnk;
        o_cmd_val = val;
        @(posedge i_clk_sys);
        #1;
        rv = i_rsp_valid;
        st = i_rsp_status;
        v = i_rsp_value;
        o_cmd_valid = 1'b0;
        o_cmd_instr = ~ins;
        o_cmd_type = ~typ;
        o_cmd_bank = ~bnk;
        o_cmd_val = ~val;
    endtask : send
endmodule : host_model

`default_nettype wire

/* tb_top.sv */
// Purpose: self-checking bench of the port-read / calculate / compare slice
// Assumes: host_model drives commands, bench drives pins and analog values
// Notes: pins settle six edges before a read that depends on them
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import io_alu_pkg::*;

    logic clk_sys, rst_n, cmd_valid, standalone, rsp_valid, enc_zero;
    logic flag_eq, flag_gt, flag_lt, cond_met, rv;
    logic [7:0] cmd_instr, cmd_type, cmd_bank, rsp_status, rs;
    logic [31:0] cmd_val, rsp_value, acc, rval;
    logic [3:0] gen_in, cond_code;
    logic [11:0] adc0;
    logic [15:0] supply, temp;
    logic [1:0] gen_out;
    logic [31:0] flags_seen;
    int n_fail = 0;
    int comparisons = 0;

    // flags packed for one-line compares
    assign flags_seen = {29'h0, flag_eq, flag_gt, flag_lt};

    // clock at 200 MHz
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    host_model host (.i_clk_sys(clk_sys), .o_cmd_valid(cmd_valid),
        .o_standalone(standalone), .o_cmd_instr(cmd_instr),
        .o_cmd_type(cmd_type), .o_cmd_bank(cmd_bank), .o_cmd_val(cmd_val),
        .i_rsp_valid(rsp_valid), .i_rsp_status(rsp_status),
        .i_rsp_value(rsp_value));

    io_read_accumulator_alu uut (.i_clk_sys(clk_sys), .i_nrst(rst_n),
        .i_cmd_valid(cmd_valid), .i_standalone(standalone),
        .i_cmd_instr(cmd_instr), .i_cmd_type(cmd_type),
        .i_cmd_bank(cmd_bank), .i_cmd_val_b3(cmd_val[31:24]),
        .i_cmd_val_b2(cmd_val[23:16]), .i_cmd_val_b1(cmd_val[15:8]),
        .i_cmd_val_b0(cmd_val[7:0]), .o_rsp_valid(rsp_valid),
        .o_rsp_status(rsp_status), .o_rsp_value(rsp_value),
        .i_general_input(gen_in), .i_enc_near_zero(enc_zero),
        .i_adc_in0(adc0), .i_supply_tenths_v(supply),
        .i_temp_celsius(temp), .i_general_output(gen_out), .o_acc(acc),
        .o_flag_eq(flag_eq), .o_flag_gt(flag_gt), .o_flag_lt(flag_lt),
        .i_cond_code(cond_code), .o_cond_met(cond_met));

    // compare seen against expected, count both outcomes
    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // one command through the host, reply pulse must be present
    task automatic cmd(input logic sa, input logic [7:0] ins,
        input logic [7:0] typ, input logic [7:0] bnk, input logic [31:0] v);
        host.send(sa, ins, typ, bnk, v, rv, rs, rval);
        check("rsp_valid", {31'h0, rv}, 32'h1);
    endtask : cmd

    // pins change, then wait out the input synchroniser
    task automatic settle();
        repeat (6) @(posedge clk_sys);
    endtask : settle

    // digital bank: single lines, packed vector, encoder zero
    task automatic t_digital();
        logic [31:0] a0;
        cmd(1'b1, 8'h13, 8'h09, 8'h00, 32'h12345678);
        a0 = acc;
        gen_in = 4'ha;
        enc_zero = 1'b1;
        settle();
        for (int p = 0; p < 4; p++) begin
            cmd(1'b0, 8'h0f, p[7:0], 8'h00, 32'h0);
            check("din bit", rval, {31'h0, gen_in[p]});
        end
        cmd(1'b0, 8'h0f, 8'hff, 8'h00, 32'h0);
        check("din all", rval, 32'h0000000a);
        cmd(1'b0, 8'h0f, 8'h0b, 8'h00, 32'h0);
        check("enc zero", rval, 32'h1);
        check("acc direct", acc, a0);
        gen_in = 4'h5;
        settle();
        cmd(1'b1, 8'h0f, 8'hff, 8'h00, 32'h0);
        check("acc standalone", acc, 32'h00000005);
        $display("test digital done");
    endtask : t_digital

    // analog bank, output readback, unmapped bank
    task automatic t_analog();
        adc0 = 12'hfff;
        supply = 16'h00f0;
        temp = 16'hfffb;
        gen_out = 2'b10;
        gen_in = 4'h1;
        settle();
        cmd(1'b0, 8'h0f, 8'h00, 8'h01, 32'h0);
        check("adc0", rval, 32'h00000fff);
        check("adc status", {24'h0, rs}, 32'h64);
        cmd(1'b0, 8'h0f, 8'h08, 8'h01, 32'h0);
        check("supply", rval, 32'h000000f0);
        cmd(1'b0, 8'h0f, 8'h09, 8'h01, 32'h0);
        check("temp", rval, 32'hfffffffb);
        cmd(1'b0, 8'h0f, 8'h00, 8'h00, 32'h0);
        check("in0 digital", rval, 32'h1);
        cmd(1'b1, 8'h0f, 8'h00, 8'h01, 32'h0);
        check("acc adc0", acc, 32'h00000fff);
        cmd(1'b0, 8'h0f, 8'h00, 8'h02, 32'h0);
        check("general_output_0", rval, 32'h0);
        cmd(1'b0, 8'h0f, 8'h01, 8'h02, 32'h0);
        check("general_output_1", rval, 32'h1);
        cmd(1'b1, 8'h0f, 8'h00, 8'h03, 32'h0);
        check("bad bank", {24'h0, rs}, 32'h03);
        check("bad bank value", rval, 32'h0);
        check("bad bank acc", acc, 32'h00000fff);
        $display("test analog done");
    endtask : t_analog

    // every calculate code in turn, then divide by zero and a bad code
    task automatic t_accumulator_calculate();
        logic signed [31:0] e, op;
        logic signed [31:0] ops [10];
        ops = '{32'sd23, 32'sd3, -32'sd5000, 32'sd7, 32'sd1000,
            32'sh0000ffff, 32'sh00f00000, 32'shffffffff, 32'sh1234,
            32'sh7ffffff0};
        cmd(1'b1, 8'h13, 8'h09, 8'h00, 32'd100);
        e = 32'sd100;
        for (int i = 0; i < 10; i++) begin
            op = ops[i];
            case (i)
                0: e = e + op;
                1: e = e - op;
                2: e = e * op;
                3: e = e / op;
                4: e = e % op;
                5: e = e & op;
                6: e = e | op;
                7: e = e ^ op;
                8: e = ~e;
                default: e = op;
            endcase
            cmd(i[0], 8'h13, i[7:0], 8'h00, op);
            check("accumulator_calculate acc", acc, e);
            check("accumulator_calculate status", {24'h0, rs}, 32'h64);
            check("accumulator_calculate value", rval, op);
        end
        cmd(1'b1, 8'h13, 8'h03, 8'h00, 32'h0);
        check("div zero", acc, e);
        cmd(1'b1, 8'h13, 8'h04, 8'h00, 32'h0);
        check("rem zero", acc, e);
        cmd(1'b1, 8'h13, 8'h0a, 8'h00, 32'h1);
        check("bad op", {24'h0, rs}, 32'h03);
        check("bad op acc", acc, e);
        // output-set is not handled here and must be refused
        cmd(1'b1, 8'h0e, 8'h00, 8'h02, 32'h1);
        check("bad instr", {24'h0, rs}, 32'h02);
        check("bad instr value", rval, 32'h0);
        check("bad instr acc", acc, e);
        $display("test accumulator_calculate done");
    endtask : t_accumulator_calculate

    // compare, flags and every branch condition code
    task automatic t_compare();
        logic signed [31:0] vals [4];
        logic eq, gt, lt, x;
        vals = '{32'sd1000, 32'sd999, 32'sd1001, -32'sd1};
        cmd(1'b1, 8'h13, 8'h09, 8'h00, 32'd1000);
        for (int i = 0; i < 4; i++) begin
            cmd(1'b0, 8'h14, 8'h33, 8'h07, vals[i]);
            eq = (vals[i] == 32'sd1000);
            gt = (32'sd1000 > vals[i]);
            lt = (32'sd1000 < vals[i]);
            check("comp status", {24'h0, rs}, 32'h64);
            check("flags", flags_seen, {29'h0, eq, gt, lt});
            for (int c = 0; c < 16; c++) begin
                case (c)
                    0, 2: x = eq;
                    1, 3: x = !eq;
                    4: x = gt;
                    5: x = gt | eq;
                    6: x = lt;
                    7: x = lt | eq;
                    default: x = 1'b0;
                endcase
                @(posedge clk_sys);
                #1;
                cond_code = c[3:0];
                #1;
                check("cond", {31'h0, cond_met}, {31'h0, x});
            end
        end
        $display("test compare done");
    endtask : t_compare

    // reset in mid-run clears accumulator, flags and reply
    task automatic t_reset();
        @(posedge clk_sys);
        #1;
        rst_n = 1'b0;
        #1;
        check("mid reset acc", acc, 32'h0);
        check("mid reset flags", flags_seen, 32'h0);
        check("mid reset status", {24'h0, rsp_status}, 32'h0);
        repeat (2) @(posedge clk_sys);
        #1;
        rst_n = 1'b1;
        cmd(1'b1, 8'h13, 8'h09, 8'h00, 32'h0000abcd);
        check("after reset acc", acc, 32'h0000abcd);
        $display("test reset done");
    endtask : t_reset

    // verdict and end of run
    task automatic end_of_test();
        $display("counts: %0d compared, %0d mismatched", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_of_test

    // watchdog, some twenty times the expected run of about 170 cycles
    initial begin
        #20000;
        n_fail++;
        end_of_test();
    end

    // main sequence
    initial begin
        rst_n = 1'b0;
        gen_in = 4'h0;
        enc_zero = 1'b0;
        adc0 = 12'h000;
        supply = 16'h0000;
        temp = 16'h0000;
        gen_out = 2'b00;
        cond_code = 4'h0;
        repeat (12) @(posedge clk_sys);
        #1;
        rst_n = 1'b1;
        check("reset acc", acc, 32'h0);
        check("reset flags", flags_seen, 32'h0);
        t_digital();
        t_analog();
        t_accumulator_calculate();
        t_compare();
        t_reset();
        end_of_test();
    end
endmodule : tb_top

`default_nettype wire
